// file: inc/dtb_pkg.sv
// Shared constants and carrier types for the backplane transfer master
package dtb_pkg;
	// Address modes
	typedef enum logic [2:0] {
		MODE_A16 = 3'h0,
		MODE_A24 = 3'h1,
		MODE_A32 = 3'h2,
		MODE_A40 = 3'h3,
		MODE_A64 = 3'h4
	} addr_mode_t;

	// Data widths per transfer
	typedef enum logic [2:0] {
		WID_D8   = 3'h0,
		WID_D16  = 3'h1,
		WID_D32  = 3'h2,
		WID_MD32 = 3'h3,
		WID_D64  = 3'h4
	} data_width_t;

	// Outcome of a cycle
	typedef enum logic [1:0] {
		END_ACK   = 2'h0,
		END_RETRY = 2'h1,
		END_BERR  = 2'h2,
		END_TIME  = 2'h3
	} cycle_end_t;

	// Timing: bus timer limit and strobe setup
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned BUS_TIMEOUT_US  = 64;
	localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * (CLK_HZ / 1000000);
	localparam int unsigned SETUP_NS        = 100;
	localparam int unsigned SETUP_CYC       = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;

	localparam int unsigned FIFO_WIDTH = 64;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned ADDR_W     = 64;
	localparam logic [7:0]  BURST_RST  = 8'h01;

	// Command from the local side
	typedef struct packed {
		logic [63:0]  addr;
		logic [5:0]   am;
		addr_mode_t   mode;
		data_width_t  width;
		logic         write;
		logic [7:0]   beats;
		logic         lock;
		logic [3:0]   byte_sel;
	} cmd_t;

	// Result of a cycle
	typedef struct packed {
		cycle_end_t   how;
		logic [7:0]   done_beats;
	} result_t;

	// Bus pin outputs; each _oe_n low means the pin is driven
	typedef struct packed {
		logic [31:0]  d_o;
		logic         d_oe_n;
		logic [31:1]  a_o;
		logic         lword_n_o;
		logic         a_oe_n;
		logic [5:0]   am_o;
		logic         as_n_o;
		logic         ds0_n_o;
		logic         ds1_n_o;
		logic         write_n_o;
		logic         lock_n_o;
		logic         ctl_oe_n;
	} bus_out_t;

	// Bus pin inputs
	typedef struct packed {
		logic [31:0]  d_i;
		logic [31:1]  a_i;
		logic         lword_n_i;
		logic         dtack_n_i;
		logic         berr_n_i;
		logic         retry_n_i;
	} bus_in_t;
endpackage

// file: verilog/dtb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dtb_fifo #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0]  wr;
		logic [AW:0]  rd;
	} fifo_state_t;

	fifo_state_t      st_reg;
	fifo_state_t      st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_reg;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	assign full      = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
	assign empty     = (st_reg.wr == st_reg.rd);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;
	assign out_data  = rd_data_reg;

	always_comb begin
		st_next = st_reg;
		if (push)
			st_next.wr = st_reg.wr + 1'b1;
		if (pop)
			st_next.rd = st_reg.rd + 1'b1;
	end

	// Registered read port follows the next head; a word landing in that slot now bypasses the array
	always_ff @(posedge ref_clk) begin
		if (push)
			mem[st_reg.wr[AW-1:0]] <= in_data;
		if (push && st_reg.wr[AW-1:0] == st_next.rd[AW-1:0])
			rd_data_reg <= in_data;
		else
			rd_data_reg <= mem[st_next.rd[AW-1:0]];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule

// file: verilog/dtb_master.sv
// Backplane transfer bus master: drives the bus pins for one cycle per command
`timescale 1ns/100ps
// How it works
// [R1] Cycle stays open, strobes held, until a responder answers or the timer fires.
// [R2] Own bus timer ends any unanswered cycle and reports a timeout.
// [R3] Location monitoring is the slaves' affair; master issues ordinary accesses.
// [R4] 64-bit beats put data on both data and address lines.
// [R5] A64 mode: upper address bits travel on data lines in address phase.
// [R6] A40 mode: address bits 39..24 on data lines, primary connector only.
// [R7] Multiplexed 32-bit beat uses D[15..0] plus A[15..1] and LWORD.
// [R8] A40 block cycles accept 8, 16 and 32 bit beat widths.
// [R9] Reads: address broadcast, then data phase; writes drive data with address.
// [R10] Single reads perform exactly one beat after the address phase.
// [R11] Block cycles perform many beats after one address broadcast.
// [R12] A40 and A64 cycles always run address phase first, then data.
// [R13] Each beat ends on acknowledge, retry or bus error low, or when the bus timer fires.
// [R14] Strobe levels pick bytes; falling strobe edges time each beat.
// [R15] Address lines carry address, then data in 64-bit and multiplexed 32-bit beats.
// [R16] Data lines carry data, plus address in A40/A64 broadcast.
// [R17] Lock request holds the lock line low over the whole command.
// [R18] Active-low pins asserted low, acted on at falling edges.
// [R19] Strobes held until response, released before the next beat.
// [R20] Slave answers after data valid; read data captured at the answer.
module dtb_master #(
	parameter int unsigned TIMEOUT_CYC = dtb_pkg::BUS_TIMEOUT_CYC,
	parameter int unsigned FIFO_DEPTH  = dtb_pkg::FIFO_DEPTH
) (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire dtb_pkg::cmd_t     cmd,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic [63:0]       wr_data,
	input  wire logic              wr_valid,
	output logic                   wr_ready,
	output logic      [63:0]       rd_data,
	output logic                   rd_valid,
	input  wire logic              rd_ready,
	output dtb_pkg::result_t       result,
	output logic                   result_valid,
	output dtb_pkg::bus_out_t      bus_o,
	input  wire dtb_pkg::bus_in_t  bus_i
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_SETUP = 3'h2,
		ST_WAIT  = 3'h3,
		ST_REL   = 3'h4,
		ST_DONE  = 3'h5
	} phase_t;

	typedef struct packed {
		phase_t             phase;
		dtb_pkg::cmd_t      c;
		dtb_pkg::bus_out_t  bo;
		logic [31:0]        timer;
		logic [7:0]         beat;
		logic               odd_lane;
		dtb_pkg::result_t   res;
		logic               res_valid;
		logic [63:0]        rdata;
		logic               rpush;
	} master_state_t;

	master_state_t st_reg;
	master_state_t st_next;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	dtb_pkg::bus_in_t sync1_reg;
	dtb_pkg::bus_in_t sync2_reg;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= bus_i;
			sync2_reg <= sync1_reg;
		end
	end

	// ------------------------------------------------------------
	// Data FIFOs
	// ------------------------------------------------------------
	logic [63:0] wf_data;
	logic        wf_valid;
	logic        wf_pop;
	logic        rf_in_ready;

	dtb_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_data   (wr_data),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.out_data  (wf_data),
		.out_valid (wf_valid),
		.out_ready (wf_pop)
	);

	// Read side stalls the master when full, so the reader pushes back
	dtb_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_data   (st_reg.rdata),
		.in_valid  (st_reg.rpush),
		.in_ready  (rf_in_ready),
		.out_data  (rd_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	logic answered;
	logic two_phase;
	logic beat_ok;

	assign answered  = !sync2_reg.dtack_n_i || !sync2_reg.berr_n_i || !sync2_reg.retry_n_i; // [R13] [R18]
	assign two_phase = !st_reg.c.write || st_reg.c.mode == dtb_pkg::MODE_A40 ||
		st_reg.c.mode == dtb_pkg::MODE_A64 || st_reg.c.width == dtb_pkg::WID_D64
		|| st_reg.c.width == dtb_pkg::WID_MD32; // [R9] [R12]
	// A write beat needs data ready; a read beat needs room to store
	assign beat_ok   = st_reg.c.write ? wf_valid : rf_in_ready;
	assign cmd_ready = st_reg.phase == ST_IDLE;
	assign wf_pop    = st_reg.phase == ST_SETUP && st_reg.c.write && beat_ok && st_reg.timer == '0
		&& !answered && st_reg.bo.ds0_n_o && st_reg.bo.ds1_n_o;
	assign bus_o        = st_reg.bo;
	assign result       = st_reg.res;
	assign result_valid = st_reg.res_valid;

	// Address pins for the broadcast phase, per mode
	function automatic dtb_pkg::bus_out_t drive_addr(input dtb_pkg::cmd_t c, input dtb_pkg::bus_out_t b);
		dtb_pkg::bus_out_t r;
		r           = b;
		r.a_o       = c.addr[31:1];
		r.lword_n_o = !(c.byte_sel == 4'hF);
		r.a_oe_n    = 1'b0;
		r.am_o      = c.am; // [R3] Full broadcast lets monitors see every access
		r.d_oe_n    = 1'b1;
		unique case (c.mode)
			dtb_pkg::MODE_A16: r.a_o[31:16] = '0;
			dtb_pkg::MODE_A24: r.a_o[31:24] = '0;
			dtb_pkg::MODE_A32: ;
			dtb_pkg::MODE_A40: begin // [R6] [R16]
				r.a_o[31:24] = '0;
				r.d_o        = {16'h0000, c.addr[31:24], c.addr[39:32]};
				r.d_oe_n     = 1'b0;
			end
			dtb_pkg::MODE_A64: begin // [R5] [R16]
				r.d_o    = c.addr[63:32];
				r.d_oe_n = 1'b0;
			end
			default: r.a_o = c.addr[31:1];
		endcase
		// 64-bit beats: all lane selects low in address phase
		if (c.width == dtb_pkg::WID_D64) begin
			r.lword_n_o = 1'b0;
			r.a_o[2:1]  = 2'b00;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		st_next.res_valid = 1'b0;
		st_next.rpush     = 1'b0;
		unique case (st_reg.phase)
			ST_IDLE: begin
				if (cmd_valid) begin
					st_next.c        = cmd;
					st_next.beat     = '0;
					st_next.odd_lane = cmd.byte_sel[1] && !cmd.byte_sel[0];
					st_next.bo       = drive_addr(cmd, st_reg.bo);
					st_next.bo.write_n_o = !cmd.write;
					st_next.bo.lock_n_o  = !cmd.lock; // [R17]
					st_next.bo.ctl_oe_n  = 1'b0;
					st_next.timer    = 32'(dtb_pkg::SETUP_CYC);
					st_next.phase    = ST_ADDR;
				end
			end
			ST_ADDR: begin
				// Address setup before the address strobe falls
				if (st_reg.timer != '0)
					st_next.timer = st_reg.timer - 1'b1;
				else begin
					st_next.bo.as_n_o = 1'b0; // [R18]
					st_next.phase     = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (st_reg.timer != '0)
					st_next.timer = st_reg.timer - 1'b1;
				else if (beat_ok && !answered) begin
					// Data lines now carry data; address lines too for wide beats
					if (two_phase) begin
						st_next.bo.d_oe_n = 1'b1; // [R9]
						if (st_reg.c.width == dtb_pkg::WID_D64 || st_reg.c.width == dtb_pkg::WID_MD32)
							st_next.bo.a_oe_n = 1'b1; // [R15]
					end
					if (st_reg.c.write) begin
						st_next.bo.d_oe_n = 1'b0;
						st_next.bo.d_o    = wf_data[31:0];
						if (st_reg.c.width == dtb_pkg::WID_D64) begin // [R4] [R15]
							st_next.bo.a_oe_n    = 1'b0;
							st_next.bo.a_o       = wf_data[63:33];
							st_next.bo.lword_n_o = wf_data[32];
						end else if (st_reg.c.width == dtb_pkg::WID_MD32) begin // [R7]
							st_next.bo.a_oe_n         = 1'b0;
							st_next.bo.d_o            = {16'h0000, wf_data[15:0]};
							st_next.bo.a_o[15:1]      = wf_data[31:17];
							st_next.bo.lword_n_o      = wf_data[16];
						end
					end
					// Strobe levels pick lanes; single-byte blocks alternate
					if (st_reg.c.width == dtb_pkg::WID_D8) begin // [R14] [R8]
						st_next.bo.ds1_n_o = st_reg.odd_lane;
						st_next.bo.ds0_n_o = !st_reg.odd_lane;
					end else begin
						st_next.bo.ds1_n_o = 1'b0;
						st_next.bo.ds0_n_o = 1'b0;
					end
					st_next.timer = '0;
					st_next.phase = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Strobes held until answered or timed out
				if (answered) begin // [R1] [R19] [R20]
					st_next.rdata = {sync2_reg.a_i, sync2_reg.lword_n_i, sync2_reg.d_i};
					if (st_reg.c.width == dtb_pkg::WID_MD32)
						st_next.rdata = {32'h0, sync2_reg.a_i[15:1], sync2_reg.lword_n_i, sync2_reg.d_i[15:0]};
					st_next.rpush = !st_reg.c.write && !sync2_reg.dtack_n_i;
					st_next.bo.ds0_n_o = 1'b1;
					st_next.bo.ds1_n_o = 1'b1;
					st_next.beat       = st_reg.beat + 1'b1;
					st_next.timer      = 32'(dtb_pkg::SETUP_CYC);
					st_next.odd_lane   = !st_reg.odd_lane;
					st_next.res.how    = !sync2_reg.berr_n_i ? dtb_pkg::END_BERR :
						!sync2_reg.retry_n_i ? dtb_pkg::END_RETRY : dtb_pkg::END_ACK;
					st_next.phase      = ST_REL;
				end else if (st_reg.timer >= 32'(TIMEOUT_CYC - 1)) begin // [R2]
					st_next.bo.ds0_n_o = 1'b1;
					st_next.bo.ds1_n_o = 1'b1;
					st_next.res.how    = dtb_pkg::END_TIME;
					st_next.phase      = ST_DONE;
				end else
					st_next.timer = st_reg.timer + 1'b1;
			end
			ST_REL: begin
				// Wait for the answer to go away before the next beat
				if (!answered) begin
					if (st_reg.res.how == dtb_pkg::END_ACK && st_reg.beat < st_reg.c.beats) // [R10] [R11]
						st_next.phase = ST_SETUP;
					else
						st_next.phase = ST_DONE;
				end
			end
			ST_DONE: begin
				st_next.bo.as_n_o      = 1'b1;
				st_next.bo.ctl_oe_n    = 1'b1;
				st_next.bo.d_oe_n      = 1'b1;
				st_next.bo.a_oe_n      = 1'b1;
				st_next.bo.lock_n_o    = 1'b1;
				st_next.res.done_beats = st_reg.beat;
				st_next.res_valid      = 1'b1;
				st_next.phase          = ST_IDLE;
			end
			default: st_next.phase = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg                <= '0;
			st_reg.phase          <= ST_IDLE;
			st_reg.c.beats        <= dtb_pkg::BURST_RST;
			st_reg.bo.d_oe_n      <= 1'b1;
			st_reg.bo.a_oe_n      <= 1'b1;
			st_reg.bo.ctl_oe_n    <= 1'b1;
			st_reg.bo.as_n_o      <= 1'b1;
			st_reg.bo.ds0_n_o     <= 1'b1;
			st_reg.bo.ds1_n_o     <= 1'b1;
			st_reg.bo.write_n_o   <= 1'b1;
			st_reg.bo.lock_n_o    <= 1'b1;
			st_reg.bo.lword_n_o   <= 1'b1;
		end else
			st_reg <= st_next;
	end
endmodule

// file: testbench/dtb_master_assertions.sv
// Concurrent checks on the transfer bus master's pins and handshakes
`timescale 1ns/100ps
module dtb_master_assertions #(
	parameter int unsigned TIMEOUT_CYC = dtb_pkg::BUS_TIMEOUT_CYC
) (
	input wire logic              ref_clk,
	input wire logic              arst_n,
	input wire logic              cmd_ready,
	input wire logic              result_valid,
	input wire dtb_pkg::bus_out_t bus_o,
	input wire dtb_pkg::bus_in_t  bus_i
);
	logic        strb;
	logic        quiet;
	logic [15:0] ds_cnt_reg;

	assign strb  = !(bus_o.ds0_n_o && bus_o.ds1_n_o);
	assign quiet = bus_i.dtack_n_i && bus_i.berr_n_i && bus_i.retry_n_i;

	// Age of the current strobe, bounds the bus timer
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			ds_cnt_reg <= 16'h0000;
		else
			ds_cnt_reg <= strb ? ds_cnt_reg + 16'h0001 : 16'h0000;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	AST_BUSY: assert property (!bus_o.as_n_o |-> !cmd_ready)
		else $error("command accepted in an open cycle");
	// Margin of four cycles covers the answer synchroniser
	AST_HOLD: assert property ((strb && quiet && $past(quiet) && ds_cnt_reg < TIMEOUT_CYC - 4) |=> strb)
		else $error("strobe dropped without an answer");
	AST_TIMER: assert property (ds_cnt_reg <= TIMEOUT_CYC + 4)
		else $error("unanswered strobe outlived the bus timer");
	AST_RELEASE: assert property ((strb && !quiet) |-> ##[1:5] !strb)
		else $error("strobe not released after the answer");
	AST_INTERLOCK: assert property ((!strb && !bus_i.dtack_n_i) |=> !strb)
		else $error("new strobe while acknowledge still low");
	AST_AS_FIRST: assert property (strb |-> !bus_o.as_n_o)
		else $error("data strobe without address strobe");
	AST_SETUP: assert property ($fell(bus_o.as_n_o) |-> !$past(bus_o.a_oe_n, 2) && !$past(bus_o.ctl_oe_n, 2))
		else $error("address strobe before address setup");
	AST_IDLE: assert property (bus_o.ctl_oe_n |-> bus_o.as_n_o && !strb && bus_o.lock_n_o)
		else $error("control asserted while not driven");
	AST_WR_DATA: assert property ((strb && !bus_o.write_n_o) |-> !bus_o.d_oe_n)
		else $error("write strobe without data driven");
	AST_RD_FLOAT: assert property ((strb && bus_o.write_n_o) |-> bus_o.d_oe_n)
		else $error("master drives data during a read");
	AST_PULSE: assert property (result_valid |=> !result_valid)
		else $error("result longer than one cycle");
endmodule

bind dtb_master dtb_master_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) watch_u (.ref_clk(ref_clk), .arst_n(arst_n),
	.cmd_ready(cmd_ready), .result_valid(result_valid), .bus_o(bus_o), .bus_i(bus_i));

// file: testbench/dtb_slave_model.sv
// Slave device model: sixteen 64-bit words answering on the transfer bus
`timescale 1ns/100ps
module dtb_slave_model (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire dtb_pkg::bus_out_t bus_o,
	output dtb_pkg::bus_in_t       bus_i,
	input  wire logic [7:0]        delay,
	input  wire logic [1:0]        kind,
	output logic      [31:0]       hi_addr
);
	logic [63:0] mem [16];
	logic [63:0] rdv_reg;
	logic [2:0]  ans_reg;
	logic [7:0]  cnt_reg;
	logic [3:0]  idx_reg;
	logic        as_reg;
	logic        drive_reg;
	logic        strb;

	assign strb = !(bus_o.ds0_n_o && bus_o.ds1_n_o);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			as_reg    <= 1'b1;
			ans_reg   <= 3'h7;
			cnt_reg   <= 8'h00;
			drive_reg <= 1'b0;
			rdv_reg   <= 64'h0;
		end else begin
			as_reg <= bus_o.as_n_o;
			if (as_reg && !bus_o.as_n_o) begin
				idx_reg <= bus_o.a_o[6:3];
				hi_addr <= bus_o.d_o;
			end
			// Kind three never answers, leaving the master's timer to end it
			if (strb && ans_reg == 3'h7 && kind != 2'h3) begin
				cnt_reg <= cnt_reg + 8'h01;
				if (cnt_reg == delay && !bus_o.write_n_o)
					mem[idx_reg] <= {bus_o.a_o, bus_o.lword_n_o, bus_o.d_o};
				if (cnt_reg == delay && bus_o.write_n_o) begin
					rdv_reg   <= mem[idx_reg];
					drive_reg <= 1'b1;
				end
				if (cnt_reg == delay + 8'h01)
					ans_reg <= ~(3'h1 << kind);
			end else if (!strb && ans_reg != 3'h7) begin
				ans_reg   <= 3'h7;
				drive_reg <= 1'b0;
				cnt_reg   <= 8'h00;
				idx_reg   <= idx_reg + 4'h1;
			end
		end
	end

	assign bus_i.dtack_n_i = ans_reg[0];
	assign bus_i.retry_n_i = ans_reg[1];
	assign bus_i.berr_n_i  = ans_reg[2];
	// Released lines show the inverse of the last word, so stale data never matches
	assign bus_i.d_i = !bus_o.d_oe_n ? bus_o.d_o : (drive_reg ? rdv_reg[31:0] : ~rdv_reg[31:0]);
	assign {bus_i.a_i, bus_i.lword_n_i} = !bus_o.a_oe_n ? {bus_o.a_o, bus_o.lword_n_o} :
		(drive_reg ? rdv_reg[63:32] : ~rdv_reg[63:32]);
endmodule

// file: testbench/tb.sv
// Self-checking bench: transfer bus master against the slave memory model
`timescale 1ns/100ps
module tb;
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	dtb_pkg::cmd_t     cmd = '0;
	logic              cmd_valid = 1'b0;
	logic              cmd_ready;
	logic [63:0]       wr_data = 64'h0;
	logic              wr_valid = 1'b0;
	logic              wr_ready;
	logic [63:0]       rd_data;
	logic              rd_valid;
	logic              rd_ready = 1'b1;
	dtb_pkg::result_t  result;
	logic              result_valid;
	dtb_pkg::bus_out_t bus_o;
	dtb_pkg::bus_in_t  bus_i;
	logic [7:0]        delay = 8'h00;
	logic [1:0]        kind = 2'h0;
	logic [31:0]       hi_addr;
	int                num_errors = 0;
	int                n_checks = 0;
	logic [63:0]       got[$];
	logic [2:0]        lanes[$];
	logic              strb_seen = 1'b0;

	always #25 ref_clk = ~ref_clk;

	// Lock and strobe levels at each new beat, taken mid-cycle where they are settled
	always @(negedge ref_clk) begin
		strb_seen <= !(bus_o.ds0_n_o && bus_o.ds1_n_o);
		if (!(bus_o.ds0_n_o && bus_o.ds1_n_o) && !strb_seen)
			lanes.push_back({bus_o.lock_n_o, bus_o.ds1_n_o, bus_o.ds0_n_o});
	end

	// Short bus timer keeps the timeout case brief
	dtb_master #(.TIMEOUT_CYC(32)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .result(result), .result_valid(result_valid), .bus_o(bus_o),
		.bus_i(bus_i));
	dtb_slave_model slave (.ref_clk(ref_clk), .arst_n(arst_n), .bus_o(bus_o), .bus_i(bus_i), .delay(delay),
		.kind(kind), .hi_addr(hi_addr));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic dtb_pkg::cmd_t mk(input dtb_pkg::addr_mode_t m, input dtb_pkg::data_width_t w,
			input logic wr, input logic [7:0] n, input logic [63:0] a);
		return '{addr: a, am: 6'h0D, mode: m, width: w, write: wr, beats: n, lock: 1'b1, byte_sel: 4'hF};
	endfunction

	task automatic tick();
		@(posedge ref_clk);
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			got.push_back(rd_data);
	endtask

	task automatic fill(input int n, input logic [63:0] base);
		for (int k = 0; k < n; k++) begin
			wr_data  <= base + 64'(k);
			wr_valid <= 1'b1;
			do @(posedge ref_clk); while (wr_ready !== 1'b1);
		end
		wr_valid <= 1'b0;
	endtask

	task automatic run(input dtb_pkg::cmd_t c, input dtb_pkg::cycle_end_t how, input logic [7:0] nb);
		cmd       <= c;
		cmd_valid <= 1'b1;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		for (int i = 0; i < 3000 && result_valid !== 1'b1; i++)
			tick();
		chk(64'(result_valid), 64'h1, "result pulse");
		chk(64'(result.how), 64'(how), "cycle end");
		if (nb != 8'hFF)
			chk(64'(result.done_beats), 64'(nb), "beats");
	endtask

	task automatic drain();
		rd_ready <= 1'b1;
		repeat (40) tick();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(64'({cmd_ready, result_valid, rd_valid, wr_ready, bus_o.ctl_oe_n, bus_o.d_oe_n, bus_o.a_oe_n,
			bus_o.as_n_o}), 64'h9F, "reset state");
	endtask

	task automatic t_modes();
		dtb_pkg::addr_mode_t ms[3] = '{dtb_pkg::MODE_A16, dtb_pkg::MODE_A24, dtb_pkg::MODE_A32};
		delay <= 8'h0A;
		foreach (ms[k]) begin
			fill(1, 64'h1234_5670 + 64'(k));
			run(mk(ms[k], dtb_pkg::WID_D32, 1'b1, 8'h01, 64'h10), dtb_pkg::END_ACK, 8'h01);
			run(mk(ms[k], dtb_pkg::WID_D32, 1'b0, 8'h01, 64'h10), dtb_pkg::END_ACK, 8'h01);
			drain();
			chk(64'(got.size()), 64'h1, "read words");
			chk(64'(got[0][31:0]), 64'h1234_5670 + 64'(k), "single data");
			got.delete();
		end
		delay <= 8'h00;
	endtask

	task automatic t_a64();
		run(mk(dtb_pkg::MODE_A64, dtb_pkg::WID_D32, 1'b0, 8'h01, 64'hAB00_0000_0000_0010),
			dtb_pkg::END_ACK, 8'h01);
		drain();
		chk(64'(hi_addr), 64'hAB00_0000, "upper address");
		chk(64'(got[0][31:0]), 64'h1234_5672, "wide address data");
		got.delete();
	endtask

	task automatic t_mblt();
		fill(16, 64'h8765_4321_0FED_CB00);
		@(posedge ref_clk);
		chk(64'(wr_ready), 64'h0, "write buffer full");
		run(mk(dtb_pkg::MODE_A32, dtb_pkg::WID_D64, 1'b1, 8'h10, 64'h0), dtb_pkg::END_ACK, 8'h10);
		chk(64'(wr_ready), 64'h1, "write buffer empty");
		rd_ready <= 1'b0;
		run(mk(dtb_pkg::MODE_A32, dtb_pkg::WID_D64, 1'b0, 8'h10, 64'h0), dtb_pkg::END_ACK, 8'h10);
		chk(64'(rd_valid), 64'h1, "held read data");
		drain();
		chk(64'(got.size()), 64'h10, "block words");
		foreach (got[k])
			chk(got[k], 64'h8765_4321_0FED_CB00 + 64'(k), "wide beat");
		got.delete();
	endtask

	task automatic t_a40();
		fill(2, 64'hCAFE_0000);
		run(mk(dtb_pkg::MODE_A40, dtb_pkg::WID_MD32, 1'b1, 8'h02, 64'h5A_3C00_0040), dtb_pkg::END_ACK, 8'h02);
		run(mk(dtb_pkg::MODE_A40, dtb_pkg::WID_MD32, 1'b0, 8'h02, 64'h5A_3C00_0040), dtb_pkg::END_ACK, 8'h02);
		drain();
		chk(64'(hi_addr[15:0]), 64'h3C5A, "short upper address");
		chk(64'(got.size()), 64'h2, "md32 words");
		foreach (got[k])
			chk(64'(got[k][31:0]), 64'hCAFE_0000 + 64'(k), "md32 beat");
		got.delete();
	endtask

	task automatic t_bytes();
		dtb_pkg::cmd_t c;
		c          = mk(dtb_pkg::MODE_A40, dtb_pkg::WID_D8, 1'b1, 8'h02, 64'h01_0000_0020);
		c.byte_sel = 4'h2;
		fill(2, 64'h0000_00A0);
		lanes.delete();
		run(c, dtb_pkg::END_ACK, 8'h02);
		chk(64'(lanes.size()), 64'h2, "byte beats");
		chk(64'(lanes[0]), 64'h2, "first byte lane");
		chk(64'(lanes[1]), 64'h1, "second byte lane");
		c.write = 1'b0;
		run(c, dtb_pkg::END_ACK, 8'h02);
		fill(1, 64'h0000_B016);
		run(mk(dtb_pkg::MODE_A24, dtb_pkg::WID_D16, 1'b1, 8'h01, 64'h30), dtb_pkg::END_ACK, 8'h01);
		run(mk(dtb_pkg::MODE_A24, dtb_pkg::WID_D16, 1'b0, 8'h01, 64'h30), dtb_pkg::END_ACK, 8'h01);
		drain();
		chk(64'(got.size()), 64'h3, "narrow words");
		chk(64'(got[0][31:0]), 64'hA0, "first byte");
		chk(64'(got[1][31:0]), 64'hA1, "second byte");
		chk(64'(got[2][31:0]), 64'hB016, "double byte");
		got.delete();
	endtask

	task automatic t_errors();
		for (int k = 1; k < 4; k++) begin
			kind <= 2'(k);
			run(mk(dtb_pkg::MODE_A32, dtb_pkg::WID_D32, 1'b0, 8'h01, 64'h10),
				dtb_pkg::cycle_end_t'(2'(k)), 8'hFF);
			drain();
			chk(64'(got.size()), 64'h0, "data on error");
			got.delete();
		end
		kind <= 2'h0;
	endtask

	initial begin
		repeat (19) @(posedge ref_clk);
		t_reset();
		@(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_modes();
		t_a64();
		t_mblt();
		t_a40();
		t_bytes();
		t_errors();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end
endmodule
